/* File: include/mtp_cfg.svh */
// Constants for the memory access block on the two-wire slave link.
// Assumes a 40 MHz core clock and a byte-wide store of 2048 locations.
`ifndef MTP_CFG_SVH
`define MTP_CFG_SVH

// ==========================================================
// Clock and timing
`define MTP_CLK_PERIOD_NS 25
`define MTP_PROG_TIME_US 200
`define MTP_PROG_CYCLES (((`MTP_PROG_TIME_US * 1000) + `MTP_CLK_PERIOD_NS - 1) / `MTP_CLK_PERIOD_NS)
`define MTP_READ_TIME_NS 100
`define MTP_READ_CYCLES ((`MTP_READ_TIME_NS + `MTP_CLK_PERIOD_NS - 1) / `MTP_CLK_PERIOD_NS)

// ==========================================================
// Link addresses and command codes
`define MTP_GC_ADDR 7'h00
`define MTP_OWN_ADDR 7'h22
`define MTP_CMD_ADDR 8'h10
`define MTP_CMD_WRITE 8'h12
`define MTP_CMD_READ 8'h14

// ==========================================================
// Word ranges of the memory map, inclusive
`define MTP_USER2_LO 10'h080
`define MTP_USER2_HI 10'h3FF
`define MTP_CFGB_LO 10'h050
`define MTP_CFGB_HI 10'h07E
`define MTP_LOCK_LO 10'h040
`define MTP_LOCK_HI 10'h04E
`define MTP_USER1_LO 10'h012
`define MTP_USER1_HI 10'h03E
`define MTP_CFGA_LO 10'h000
`define MTP_CFGA_HI 10'h010

// ==========================================================
// Store geometry and reset values
`define MTP_ADDR_BITS 11
`define MTP_DEPTH 2048
`define MTP_BLANK_BYTE 8'hFF
`define MTP_ADDR_RESET 16'h0000

`endif

/* File: include/mtp_pkg.sv */
// Types shared by the memory access block.
// Assumes nothing of its surroundings.
package mtp_pkg;

  // ==========================================================
  // Link phase of the slave
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_CMD,
    PH_DATA,
    PH_TX
  } phase_t;

  // ==========================================================
  // Memory operation state
  typedef enum logic [1:0] {
    MEM_IDLE,
    MEM_PROG,
    MEM_READ
  } mem_st_t;

  // ==========================================================
  // Memory map region
  typedef enum logic [1:0] {
    RG_USER,
    RG_CFG,
    RG_LOCKED,
    RG_NONE
  } region_t;

endpackage

/* File: core/mtp_store.sv */
// Byte store behind the memory access block.
// Assumes one access per cycle from a controller on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "mtp_cfg.svh"

module mtp_store (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_we,
  input wire logic [`MTP_ADDR_BITS-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_q [0:`MTP_DEPTH-1];

  // ==========================================================
  // Write port
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
  end

  // ==========================================================
  // Registered read port
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= mem_q[i_addr];
    end
  end

endmodule // mtp_store
`default_nettype wire

/* File: core/mtp_i2c_access.sv */
// Memory access command handler on a two-wire slave link.
// Assumes open-drain SCL/SDA pins sampled by the 40 MHz core clock and an
// optional second user of the memory that reports its activity on i_ext_busy.
`timescale 1ns/100ps
`default_nettype none
`include "mtp_cfg.svh"

module mtp_i2c_access #(
  parameter int unsigned PROG_CYCLES = `MTP_PROG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_ext_busy,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_busy,
  output logic o_cfg_changed
);

  // ==========================================================
  // Region decode of a byte address
  function automatic mtp_pkg::region_t region_of(input logic [15:0] a);
    logic [9:0] w;
    w = a[10:1];
    if (a[15:11] != 5'h00) begin
      region_of = mtp_pkg::RG_NONE;
    end else if (w >= `MTP_LOCK_LO && w <= `MTP_LOCK_HI) begin
      region_of = mtp_pkg::RG_LOCKED;
    end else if ((w >= `MTP_USER2_LO) || (w >= `MTP_USER1_LO && w <= `MTP_USER1_HI)) begin
      region_of = mtp_pkg::RG_USER;
    end else if ((w >= `MTP_CFGB_LO && w <= `MTP_CFGB_HI) || (w <= `MTP_CFGA_HI)) begin
      region_of = mtp_pkg::RG_CFG;
    end else begin
      region_of = mtp_pkg::RG_NONE;
    end
  endfunction

  // ==========================================================
  // Pin synchronisers and edge detection
  logic scl_meta_q, scl_sync_q, scl_prev_q;
  logic sda_meta_q, sda_sync_q, sda_prev_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_meta_q <= i_scl;
      scl_sync_q <= scl_meta_q;
      scl_prev_q <= scl_sync_q;
      sda_meta_q <= i_sda;
      sda_sync_q <= sda_meta_q;
      sda_prev_q <= sda_sync_q;
    end
  end

  wire scl_rise_w = scl_sync_q & ~scl_prev_q;
  wire scl_fall_w = ~scl_sync_q & scl_prev_q;
  wire start_w = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
  wire stop_w = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;

  // ==========================================================
  // Link state
  mtp_pkg::phase_t phase_q, phase_d, next_q, next_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] hi_q, hi_d;
  logic [1:0] idx_q, idx_d;
  logic oe_q, oe_d;
  logic [15:0] addr_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic busy_q;

  // Memory activity from either user counts as busy.
  wire busy_w = busy_q | i_ext_busy;
  wire gc_w = (shift_q[7:1] == `MTP_GC_ADDR);
  wire own_w = (shift_q[7:1] == `MTP_OWN_ADDR);
  wire cmd_known_w = (shift_q == `MTP_CMD_ADDR) || (shift_q == `MTP_CMD_WRITE) ||
                     (shift_q == `MTP_CMD_READ);
  wire byte_end_w = scl_fall_w && (cnt_q == 4'h8);

  // ==========================================================
  // Acknowledge decision at the end of each received byte
  logic ack_w;
  logic set_addr_w, wr_go_w, rd_go_w;
  mtp_pkg::phase_t after_w;

  always_comb begin
    ack_w = 1'b0;
    set_addr_w = 1'b0;
    wr_go_w = 1'b0;
    rd_go_w = 1'b0;
    after_w = mtp_pkg::PH_IDLE;
    case (phase_q)
      mtp_pkg::PH_ADDR: begin
        if (!shift_q[0] && gc_w) begin
          ack_w = 1'b1;
          after_w = mtp_pkg::PH_CMD;
        end else if (shift_q[0] && (gc_w || own_w) && rd_valid_q && !busy_w) begin
          ack_w = 1'b1;
          after_w = mtp_pkg::PH_TX;
        end
      end
      mtp_pkg::PH_CMD: begin
        if (cmd_known_w && !busy_w) begin
          ack_w = 1'b1;
          after_w = mtp_pkg::PH_DATA;
          rd_go_w = (shift_q == `MTP_CMD_READ);
        end
      end
      mtp_pkg::PH_DATA: begin
        if (!busy_w && cmd_q == `MTP_CMD_ADDR && idx_q != 2'h2) begin
          ack_w = 1'b1;
          after_w = mtp_pkg::PH_DATA;
          set_addr_w = (idx_q == 2'h1);
        end else if (!busy_w && cmd_q == `MTP_CMD_WRITE && idx_q == 2'h0) begin
          ack_w = 1'b1;
          after_w = mtp_pkg::PH_DATA;
          wr_go_w = 1'b1;
        end
      end
      default: begin
        ack_w = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Bit engine next state
  logic rd_taken_w;

  always_comb begin
    phase_d = phase_q;
    next_d = next_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    cmd_d = cmd_q;
    hi_d = hi_q;
    idx_d = idx_q;
    oe_d = oe_q;
    rd_taken_w = 1'b0;
    if (start_w) begin
      phase_d = mtp_pkg::PH_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_w) begin
      phase_d = mtp_pkg::PH_IDLE;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (phase_q == mtp_pkg::PH_TX) begin
      if (scl_rise_w && cnt_q < 4'h8) begin
        cnt_d = cnt_q + 4'h1;
      end else if (scl_rise_w) begin
        phase_d = mtp_pkg::PH_IDLE;
        cnt_d = 4'h0;
        rd_taken_w = 1'b1;
      end else if (byte_end_w) begin
        oe_d = 1'b0;
      end else if (scl_fall_w && cnt_q != 4'h0) begin
        tx_d = {tx_q[6:0], 1'b1};
        oe_d = ~tx_q[6];
      end
    end else if (phase_q != mtp_pkg::PH_IDLE) begin
      if (scl_rise_w && cnt_q < 4'h8) begin
        shift_d = {shift_q[6:0], sda_sync_q};
        cnt_d = cnt_q + 4'h1;
      end else if (byte_end_w) begin
        oe_d = ack_w;
        cnt_d = 4'h9;
        next_d = after_w;
        if (ack_w && phase_q == mtp_pkg::PH_CMD) begin
          cmd_d = shift_q;
          idx_d = 2'h0;
        end
        if (ack_w && phase_q == mtp_pkg::PH_DATA) begin
          idx_d = idx_q + 2'h1;
          hi_d = (idx_q == 2'h0) ? shift_q : hi_q;
        end
      end else if (scl_fall_w && cnt_q == 4'h9) begin
        cnt_d = 4'h0;
        phase_d = next_q;
        tx_d = rd_data_q;
        oe_d = (next_q == mtp_pkg::PH_TX) ? ~rd_data_q[7] : 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      phase_q <= mtp_pkg::PH_IDLE;
      next_q <= mtp_pkg::PH_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      cmd_q <= 8'h00;
      hi_q <= 8'h00;
      idx_q <= 2'h0;
      oe_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      next_q <= next_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      cmd_q <= cmd_d;
      hi_q <= hi_d;
      idx_q <= idx_d;
      oe_q <= oe_d;
    end
  end

  // ==========================================================
  // Address register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      addr_q <= `MTP_ADDR_RESET;
    end else if (byte_end_w && set_addr_w) begin
      addr_q <= {hi_q, shift_q};
    end
  end

  // ==========================================================
  // Memory operation control
  mtp_pkg::mem_st_t mem_q;
  logic [15:0] wait_q;
  logic [7:0] store_rdata;
  logic cfg_changed_q;

  wire mtp_pkg::region_t region_w = region_of(addr_q);
  wire wr_ok_w = (region_w == mtp_pkg::RG_USER) || (region_w == mtp_pkg::RG_CFG);
  wire wr_fire_w = byte_end_w && wr_go_w && wr_ok_w;
  wire rd_fire_w = byte_end_w && rd_go_w;
  wire op_done_w = (mem_q != mtp_pkg::MEM_IDLE) && (wait_q == 16'h0000);
  wire [7:0] rd_byte_w = (addr_q[15:11] == 5'h00) ? store_rdata : `MTP_BLANK_BYTE;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mem_q <= mtp_pkg::MEM_IDLE;
      wait_q <= 16'h0000;
    end else begin
      case (mem_q)
        mtp_pkg::MEM_IDLE: begin
          if (wr_fire_w) begin
            mem_q <= mtp_pkg::MEM_PROG;
            wait_q <= 16'(PROG_CYCLES - 1);
          end else if (rd_fire_w) begin
            mem_q <= mtp_pkg::MEM_READ;
            wait_q <= 16'(`MTP_READ_CYCLES - 1);
          end
        end
        mtp_pkg::MEM_PROG, mtp_pkg::MEM_READ: begin
          if (op_done_w) begin
            mem_q <= mtp_pkg::MEM_IDLE;
          end else begin
            wait_q <= wait_q - 16'h0001;
          end
        end
        default: begin
          mem_q <= mtp_pkg::MEM_IDLE;
        end
      endcase
    end
  end

  // Busy rises with an accepted read command or a write data byte to a user or config word and falls when the store finishes.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      busy_q <= 1'b0;
    end else if (wr_fire_w || rd_fire_w) begin
      busy_q <= 1'b1;
    end else if (op_done_w) begin
      busy_q <= 1'b0;
    end
  end

  // Read data is held for the link until the master has clocked it out or another read command is accepted.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else if (op_done_w && mem_q == mtp_pkg::MEM_READ) begin
      rd_valid_q <= 1'b1;
      rd_data_q <= rd_byte_w;
    end else if (rd_fire_w || rd_taken_w) begin
      rd_valid_q <= 1'b0;
    end
  end

  // A configuration write raises the change flag, which only reset clears.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_changed_q <= 1'b0;
    end else if (wr_fire_w && region_w == mtp_pkg::RG_CFG) begin
      cfg_changed_q <= 1'b1;
    end
  end

  mtp_store u_store (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_we(wr_fire_w),
    .i_addr(addr_q[`MTP_ADDR_BITS-1:0]),
    .i_wdata(shift_q),
    .o_rdata(store_rdata)
  );

  // ==========================================================
  // Outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      o_busy <= 1'b0;
      o_cfg_changed <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
      o_sda_oe <= oe_d;
      o_busy <= busy_w;
      o_cfg_changed <= cfg_changed_q;
    end
  end

endmodule // mtp_i2c_access
`default_nettype wire

/* File: sim/mtp_i2c_access_chk.sv */
// Concurrent checks on the ports of the memory access block.
// Assumes one clock domain with a synchronous active high reset.
`timescale 1ns/100ps
`default_nettype none
`include "mtp_cfg.svh"

module mtp_i2c_access_chk #(
  parameter int unsigned PROG_CYCLES = `MTP_PROG_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_ext_busy,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_busy,
  input wire logic o_cfg_changed
);
  // ==========================================================
  // Length of the current busy run not caused by the other user
  logic [15:0] run_q;
  logic [15:0] run_d;
  assign run_d = (o_busy && !i_ext_busy) ? run_q + 16'h0001 : 16'h0000;
  always_ff @(posedge i_clk) begin
    run_q <= i_reset ? 16'h0000 : run_d;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_busy_start;
    $rose(o_busy) && !$past(i_ext_busy) && !$past(i_ext_busy, 2);
  endsequence
  sequence s_ack_start;
    $rose(o_sda_oe);
  endsequence

  AST_EXT_BUSY: assert property (i_ext_busy |=> ##[0:1] o_busy)
    else $error("busy flag misses the other user");
  AST_BUSY_MIN: assert property (s_busy_start |-> o_busy [*4])
    else $error("busy period too short");
  AST_BUSY_MAX: assert property (run_q <= PROG_CYCLES + 1)
    else $error("busy period too long");
  AST_CFG_STICKY: assert property (o_cfg_changed |=> o_cfg_changed)
    else $error("configuration change flag dropped");
  AST_CFG_CAUSE: assert property ($rose(o_cfg_changed) |-> ##[0:8] o_busy)
    else $error("configuration change without programming");
  AST_OE_SCL_LOW: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
    else $error("data line changed outside clock low");
  AST_OE_HOLD: assert property (s_ack_start |-> o_sda_oe [*6])
    else $error("acknowledge not held");
  AST_OUT_ZERO: assert property (o_sda_out == 1'b0)
    else $error("drive value not low");
endmodule // mtp_i2c_access_chk

bind mtp_i2c_access mtp_i2c_access_chk #(.PROG_CYCLES(PROG_CYCLES)) i_mtp_i2c_access_chk (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_scl(i_scl),
  .i_sda(i_sda),
  .i_ext_busy(i_ext_busy),
  .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe),
  .o_busy(o_busy),
  .o_cfg_changed(o_cfg_changed)
);

`default_nettype wire

/* File: sim/mtp_i2c_master.sv */
// Behavioural two-wire master that drives the link of the block.
// Assumes a pull-up on SDA and a 40 MHz clock pacing SCL at 200 ns.
`timescale 1ns/100ps
`default_nettype none

module mtp_i2c_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  // ==========================================================
  // SCL is low 6 clocks and high 2; it stands high between frames.
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic bitx(input logic v, output logic s);
    o_sda_pull = !v;
    tick(5);
    o_scl = 1'b1;
    tick(2);
    s = i_sda;
    o_scl = 1'b0;
    tick(1);
  endtask

  task automatic start();
    o_sda_pull = 1'b1;
    tick(2);
    o_scl = 1'b0;
    tick(1);
  endtask

  task automatic stop();
    o_sda_pull = 1'b1;
    tick(5);
    o_scl = 1'b1;
    tick(2);
    o_sda_pull = 1'b0;
    tick(4);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask

  // A single byte is taken MSB first and closed with a not-acknowledge.
  task automatic rbyte(output logic [7:0] b);
    logic s;
    b = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      b = {b[6:0], s};
    end
    bitx(1'b1, s);
  endtask
endmodule // mtp_i2c_master

`default_nettype wire

/* File: sim/test_mtp_i2c_access.sv */
// Self-checking bench for the memory access block.
// Assumes the master model, the checker and a pull-up on the SDA wire.
`timescale 1ns/100ps
`default_nettype none
`include "mtp_cfg.svh"

module test_mtp_i2c_access;
  logic i_clk;
  logic i_reset;
  logic ext_busy;
  wire logic scl;
  wire logic pull;
  wire logic sda;
  wire logic sda_out;
  wire logic sda_oe;
  wire logic busy;
  wire logic cfg_changed;
  int num_errors;
  int compares;

  assign sda = (sda_oe ? sda_out : 1'b1) & !pull;

  mtp_i2c_access #(.PROG_CYCLES(20)) i_mtp_i2c_access (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_scl(scl),
    .i_sda(sda),
    .i_ext_busy(ext_busy),
    .o_sda_out(sda_out),
    .o_sda_oe(sda_oe),
    .o_busy(busy),
    .o_cfg_changed(cfg_changed)
  );

  mtp_i2c_master i_mtp_i2c_master (
    .i_clk(i_clk),
    .i_sda(sda),
    .o_scl(scl),
    .o_sda_pull(pull)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] c, input logic [15:0] d, input int n, output logic ok);
    logic a;
    i_mtp_i2c_master.start();
    i_mtp_i2c_master.wbyte(8'h00, ok);
    i_mtp_i2c_master.wbyte(c, a);
    ok = ok & a;
    for (int i = n; i > 0; i--) begin
      i_mtp_i2c_master.wbyte(d[i*8-1 -: 8], a);
      ok = ok & a;
    end
    i_mtp_i2c_master.stop();
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0) begin
      k++;
      if (k > 200) begin
        num_errors++;
        complete_run();
      end
      i_mtp_i2c_master.tick(1);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic ok;
    cmd(`MTP_CMD_ADDR, a, 2, ok);
    check("address ack", ok, 1'b1);
    cmd(`MTP_CMD_WRITE, {8'h00, d}, 1, ok);
    check("write ack", ok, 1'b1);
  endtask

  // The read command starts the fetch; a separate read-address transfer collects the byte.
  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    logic ok;
    logic [7:0] v;
    cmd(`MTP_CMD_READ, 16'h0000, 0, ok);
    check("read ack", ok, 1'b1);
    wait_idle();
    ok = 1'b0;
    v = 8'h00;
    for (int t = 0; t < 4 && !ok; t++) begin
      i_mtp_i2c_master.start();
      i_mtp_i2c_master.wbyte(ra, ok);
      if (ok) i_mtp_i2c_master.rbyte(v);
      i_mtp_i2c_master.stop();
    end
    check("read data", v, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_user();
    wr(16'h0024, 8'hA5);
    check("prog busy", busy, 1'b1);
    rd(8'h01, 8'hA5);
    wr(16'h07FF, 8'h3C);
    rd(8'h01, 8'h3C);
    wr(16'h007C, 8'hC3);
    rd(8'h01, 8'hC3);
    wr(16'h0100, 8'h69);
    rd(8'h01, 8'h69);
    check("cfg flag user", cfg_changed, 1'b0);
  endtask

  task automatic t_protect();
    logic ok;
    wr(16'h0080, 8'h3C);
    check("locked busy", busy, 1'b0);
    wr(16'h009D, 8'h3C);
    check("locked end busy", busy, 1'b0);
    check("cfg flag locked", cfg_changed, 1'b0);
    cmd(8'h16, 16'h0000, 0, ok);
    check("unknown cmd", ok, 1'b0);
    cmd(`MTP_CMD_ADDR, 16'h0900, 2, ok);
    check("high address ack", ok, 1'b1);
    rd(8'h01, 8'hFF);
  endtask

  task automatic t_cfg();
    wr(16'h0004, 8'h5A);
    rd({`MTP_OWN_ADDR, 1'b1}, 8'h5A);
    check("cfg flag", cfg_changed, 1'b1);
    wr(16'h00FD, 8'hB4);
    rd({`MTP_OWN_ADDR, 1'b1}, 8'hB4);
  endtask

  task automatic t_busy();
    logic ok;
    wr(16'h0026, 8'h11);
    wait_idle();
    ext_busy = 1'b1;
    cmd(`MTP_CMD_ADDR, 16'h0028, 2, ok);
    check("busy address", ok, 1'b0);
    check("busy flag", busy, 1'b1);
    cmd(`MTP_CMD_WRITE, 16'h0077, 1, ok);
    check("busy write", ok, 1'b0);
    cmd(`MTP_CMD_READ, 16'h0000, 0, ok);
    check("busy read", ok, 1'b0);
    ext_busy = 1'b0;
    i_mtp_i2c_master.tick(4);
    rd(8'h01, 8'h11);
  endtask

  // Busy that arrives after an acknowledged command must refuse the data bytes that follow.
  task automatic t_midbusy();
    logic g, c, h;
    wr(16'h0028, 8'h66);
    wait_idle();
    i_mtp_i2c_master.start();
    i_mtp_i2c_master.wbyte(8'h00, g);
    i_mtp_i2c_master.wbyte(`MTP_CMD_ADDR, c);
    ext_busy = 1'b1;
    i_mtp_i2c_master.wbyte(8'h00, h);
    i_mtp_i2c_master.wbyte(8'h26, g);
    i_mtp_i2c_master.stop();
    ext_busy = 1'b0;
    check("late address cmd ack", c, 1'b1);
    check("late address data ack", h, 1'b0);
    i_mtp_i2c_master.start();
    i_mtp_i2c_master.wbyte(8'h00, g);
    i_mtp_i2c_master.wbyte(`MTP_CMD_WRITE, c);
    ext_busy = 1'b1;
    i_mtp_i2c_master.wbyte(8'h99, h);
    i_mtp_i2c_master.stop();
    ext_busy = 1'b0;
    check("late write cmd ack", c, 1'b1);
    check("late write data ack", h, 1'b0);
    rd(8'h01, 8'h66);
    i_mtp_i2c_master.start();
    i_mtp_i2c_master.wbyte(8'h01, g);
    i_mtp_i2c_master.stop();
    check("spent read address", g, 1'b0);
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    repeat (100000) @(posedge i_clk);
    num_errors++;
    complete_run();
  end

  initial begin
    num_errors = 0;
    compares = 0;
    i_reset = 1'b1;
    ext_busy = 1'b0;
    i_mtp_i2c_master.tick(3);
    i_reset = 1'b0;
    i_mtp_i2c_master.tick(4);
    t_user();
    t_protect();
    t_cfg();
    t_busy();
    t_midbusy();
    complete_run();
  end
endmodule // test_mtp_i2c_access

`default_nettype wire
